// [hdl/uart_err_mon_pkg.sv]
// Purpose: shared constants and types for the uart link error monitor
// Assumes: 32-bit classic wishbone, word per register, index*4 byte address
// Notes:   offsets are register indices, byte address is index times four
package uart_err_mon_pkg;
   // register indices
   localparam logic [10:0] IDX_CMD_FLAGS   = 11'h781;
   localparam logic [10:0] IDX_RSP_FLAGS   = 11'h782;
   localparam logic [10:0] IDX_DISCARD     = 11'h789;
   localparam logic [10:0] IDX_VALID_HI    = 11'h78C;
   localparam logic [10:0] IDX_VALID_LO    = 11'h78D;
   localparam logic [10:0] IDX_CTRL        = 11'h790;
   localparam logic [10:0] IDX_CLR_CMD     = 11'h791;
   localparam logic [10:0] IDX_CLR_RSP     = 11'h792;
   localparam logic [10:0] IDX_INT_STAT    = 11'h793;
   localparam logic [10:0] IDX_INT_EN      = 11'h794;
   localparam logic [10:0] IDX_INT_CLR     = 11'h795;
   // command flag bit positions
   localparam int CMD_INIT_BIT  = 5;
   localparam int CMD_TXDIS_BIT = 4;
   localparam int CMD_SOF_BIT   = 3;
   localparam int CMD_BYTE_BIT  = 2;
   localparam int CMD_CRC_BIT   = 0;
   // response / transmit flag bit positions
   localparam int CLEAR_DURING_TRANSMIT_ERROR_BIT    = 4;
   localparam int PENDING_RESPONSE_ABORTED_BIT   = 3;
   localparam int RESPONSE_EARLY_CLEAR_ERROR_BIT    = 2;
   localparam int RR_BYTE_BIT   = 1;
   localparam int RESPONSE_CHECKSUM_ERROR_BIT    = 0;
   // control bits and interrupt bits
   localparam int CTRL_TXEN_BIT = 0;
   localparam int CTRL_MDROP_BIT = 1;
   localparam int INT_CMD_BIT   = 0;
   localparam int INT_RSP_BIT   = 1;
   // reset values and counter saturation limits
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [7:0]  CTRL_RST  = 8'h01;
   localparam logic [7:0]  COUNT_RST = 8'h00;
   localparam logic [15:0] VALID_MAX = 16'hFFFF;
   localparam logic [7:0]  DISC_MAX  = 8'hFF;

   // per-cycle events from the uart framer, one-cycle pulses
   typedef struct packed {
      logic cmd_start;  // first byte of a command frame accepted
      logic rsp_start;  // first byte of a response frame accepted
      logic init_err;   // init byte stop error, bad type or reserved bit
      logic byte_err;   // byte error outside the init byte
      logic crc_err;    // frame ended with bad crc
      logic frame_ok;   // frame ended with good crc
      logic is_read;    // qualifies frame_ok: command was a read
      logic line_clear; // uart clear condition seen
      logic tx_start;   // response transmission begins
      logic tx_done;    // response transmission complete
   } link_evt_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_RSP, ST_IGNORE, ST_WAIT, ST_TX
   } link_state_type;
endpackage

// [hdl/uart_err_mon.sv]
// Purpose: sticky uart link error flags and frame counters on wishbone
// Assumes: framer events are same-clock single-cycle pulses
// Notes:   one ack cycle per access, unmapped reads return zero
//
// Contract
// - command init byte error sets command init flag, ignore bytes until clear.
// - ignored frame gets no error detection and no valid or discard count.
// - read command while transmitter disabled sets transmit-disabled flag.
// - clear before command frame end sets command early-clear flag.
// - non-init byte error in command sets byte flag, ignore until clear.
// - command crc failure sets command checksum flag and counts discard.
// - clear while transmitting response sets clear-during-transmit flag.
// - pending response abandoned by clear or new command sets abort flag.
// - clear during response reception sets flag; multidrop mode only.
// - response non-init byte error sets flag, ignore until clear.
// - response crc failure sets response checksum flag, counts discard.
// - eight-bit discard counter for received and transmitted frames.
// - discard read latches discard and valid registers, resets counters.
// - sixteen-bit valid counter, high and low bytes in two registers.
// - valid counter saturates at all ones instead of wrapping.
`timescale 1ns/1ps
module uart_err_mon
   import uart_err_mon_pkg::*;
(
   input  wire logic         i_ref_clk,  // core clock 100 MHz
   input  wire logic         i_nrst,     // sync reset, active low
   input  wire logic         i_wb_cyc,   // wishbone cycle
   input  wire logic         i_wb_stb,   // wishbone strobe
   input  wire logic         i_wb_we,    // wishbone write
   input  wire logic [12:0]  i_wb_adr,   // byte address
   input  wire logic [3:0]   i_wb_sel,   // byte lanes
   input  wire logic [31:0]  i_wb_dat,   // write data
   output logic      [31:0]  o_wb_dat,   // read data
   output logic              o_wb_ack,   // acknowledge
   input  wire link_evt_type i_evt,      // framer event pulses
   output logic              o_tx_enable, // transmitter enable
   output logic              o_irq       // level interrupt
);

   ////////////////////////////////////////////////////////////////////
   // bus decode
   logic        acc;
   logic        rd_hit;
   logic        wr_hit;
   logic [10:0] idx;

   assign idx    = i_wb_adr[12:2];
   assign acc    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign rd_hit = acc & ~i_wb_we;
   assign wr_hit = acc & i_wb_we & i_wb_sel[0];

   ////////////////////////////////////////////////////////////////////
   // state
   link_state_type st_q, st_d;
   logic [7:0]  cmd_q, cmd_d;
   logic [7:0]  rsp_q, rsp_d;
   logic [7:0]  disc_q, disc_d;
   logic [15:0] valid_q, valid_d;
   logic [7:0]  disc_lat_q, disc_lat_d;
   logic [15:0] valid_lat_q, valid_lat_d;
   logic [7:0]  ctrl_q, ctrl_d;
   logic [1:0]  istat_q, istat_d;
   logic [1:0]  ien_q, ien_d;
   logic        ack_d;
   logic [31:0] rdat_d;
   logic [7:0]  cmd_set;
   logic [7:0]  rsp_set;
   logic        cnt_disc;
   logic        cnt_valid;
   logic        disc_rd;

   assign disc_rd = rd_hit && idx == IDX_DISCARD;

   ////////////////////////////////////////////////////////////////////
   // frame tracker: decides flag sets and count events
   always_comb begin
      st_d      = st_q;
      cmd_set   = 8'h00;
      rsp_set   = 8'h00;
      cnt_disc  = 1'b0;
      cnt_valid = 1'b0;
      unique case (st_q)
         ST_IGNORE: begin
            // nothing is checked or counted until the clear
            if (i_evt.line_clear) begin
               st_d = ST_IDLE;
            end
         end
         ST_CMD: begin
            if (i_evt.line_clear) begin
               cmd_set[CMD_SOF_BIT] = 1'b1;
               st_d = ST_IDLE;
            end else if (i_evt.init_err) begin
               cmd_set[CMD_INIT_BIT] = 1'b1;
               st_d = ST_IGNORE;
            end else if (i_evt.byte_err) begin
               cmd_set[CMD_BYTE_BIT] = 1'b1;
               st_d = ST_IGNORE;
            end else if (i_evt.crc_err) begin
               cmd_set[CMD_CRC_BIT] = 1'b1;
               cnt_disc = 1'b1;
               st_d = ST_IDLE;
            end else if (i_evt.frame_ok) begin
               cnt_valid = 1'b1;
               if (i_evt.is_read && !ctrl_q[CTRL_TXEN_BIT]) begin
                  cmd_set[CMD_TXDIS_BIT] = 1'b1;
                  st_d = ST_IDLE;
               end else if (i_evt.is_read) begin
                  st_d = ST_WAIT;
               end else begin
                  st_d = ST_IDLE;
               end
            end
         end
         ST_RSP: begin
            if (i_evt.line_clear) begin
               rsp_set[RESPONSE_EARLY_CLEAR_ERROR_BIT] = 1'b1;
               st_d = ST_IDLE;
            end else if (i_evt.init_err || i_evt.byte_err) begin
               rsp_set[RR_BYTE_BIT] = i_evt.byte_err;
               st_d = ST_IGNORE;
            end else if (i_evt.crc_err) begin
               rsp_set[RESPONSE_CHECKSUM_ERROR_BIT] = 1'b1;
               cnt_disc = 1'b1;
               st_d = ST_IDLE;
            end else if (i_evt.frame_ok) begin
               cnt_valid = 1'b1;
               st_d = ST_IDLE;
            end
         end
         ST_WAIT: begin
            // a waiting response dies on clear or on a new command
            if (i_evt.line_clear) begin
               rsp_set[PENDING_RESPONSE_ABORTED_BIT] = 1'b1;
               st_d = ST_IDLE;
            end else if (i_evt.cmd_start) begin
               rsp_set[PENDING_RESPONSE_ABORTED_BIT] = 1'b1;
               st_d = ST_CMD;
            end else if (i_evt.tx_start) begin
               st_d = ST_TX;
            end
         end
         ST_TX: begin
            if (i_evt.line_clear) begin
               rsp_set[CLEAR_DURING_TRANSMIT_ERROR_BIT] = 1'b1;
               cnt_disc = 1'b1;
               st_d = ST_IDLE;
            end else if (i_evt.tx_done) begin
               cnt_valid = 1'b1;
               st_d = ST_IDLE;
            end
         end
         default: begin
            // idle: response frames only tracked in multidrop mode
            if (i_evt.cmd_start) begin
               st_d = ST_CMD;
            end else if (i_evt.rsp_start && ctrl_q[CTRL_MDROP_BIT]) begin
               st_d = ST_RSP;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // registers: flags, counters, latches, control, interrupt, bus
   always_comb begin
      cmd_d       = cmd_q;
      rsp_d       = rsp_q;
      disc_d      = disc_q;
      valid_d     = valid_q;
      disc_lat_d  = disc_lat_q;
      valid_lat_d = valid_lat_q;
      ctrl_d      = ctrl_q;
      istat_d     = istat_q;
      ien_d       = ien_q;
      ack_d       = acc;
      rdat_d      = 32'h0000_0000;
      // software clear first so a same-cycle set wins
      if (wr_hit && idx == IDX_CLR_CMD) begin
         cmd_d = cmd_q & ~i_wb_dat[7:0];
      end
      if (wr_hit && idx == IDX_CLR_RSP) begin
         rsp_d = rsp_q & ~i_wb_dat[7:0];
      end
      cmd_d = cmd_d | cmd_set;
      rsp_d = rsp_d | rsp_set;
      if (wr_hit && idx == IDX_CTRL) begin
         ctrl_d = {6'h00, i_wb_dat[1:0]};
      end
      if (wr_hit && idx == IDX_INT_EN) begin
         ien_d = i_wb_dat[1:0];
      end
      if (wr_hit && idx == IDX_INT_CLR) begin
         istat_d = istat_q & ~i_wb_dat[1:0];
      end
      istat_d[INT_CMD_BIT] = istat_d[INT_CMD_BIT] | (|cmd_set);
      istat_d[INT_RSP_BIT] = istat_d[INT_RSP_BIT] | (|rsp_set);
      // counters restart from zero on a discard read, event still counts
      if (disc_rd) begin
         disc_lat_d  = disc_q;
         valid_lat_d = valid_q;
         disc_d      = COUNT_RST;
         valid_d     = 16'h0000;
      end
      if (cnt_disc && disc_d != DISC_MAX) begin
         disc_d = disc_d + 8'h01;
      end
      if (cnt_valid && valid_d != VALID_MAX) begin
         valid_d = valid_d + 16'h0001;
      end
      // read mux, data sits in the low byte
      if (rd_hit) begin
         unique case (idx)
            IDX_CMD_FLAGS: rdat_d = {24'h00_0000, cmd_q};
            IDX_RSP_FLAGS: rdat_d = {24'h00_0000, rsp_q};
            IDX_DISCARD:   rdat_d = {24'h00_0000, disc_q};
            IDX_VALID_HI:  rdat_d = {24'h00_0000, valid_lat_q[15:8]};
            IDX_VALID_LO:  rdat_d = {24'h00_0000, valid_lat_q[7:0]};
            IDX_CTRL:      rdat_d = {24'h00_0000, ctrl_q};
            IDX_INT_STAT:  rdat_d = {30'h0000_0000, istat_q};
            IDX_INT_EN:    rdat_d = {30'h0000_0000, ien_q};
            default:       rdat_d = 32'h0000_0000;
         endcase
      end
   end

   // single register bank, sync reset
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         st_q        <= ST_IDLE;
         cmd_q       <= FLAGS_RST;
         rsp_q       <= FLAGS_RST;
         disc_q      <= COUNT_RST;
         valid_q     <= 16'h0000;
         disc_lat_q  <= COUNT_RST;
         valid_lat_q <= 16'h0000;
         ctrl_q      <= CTRL_RST;
         istat_q     <= 2'h0;
         ien_q       <= 2'h0;
         o_wb_ack    <= 1'b0;
         o_wb_dat    <= 32'h0000_0000;
      end else begin
         st_q        <= st_d;
         cmd_q       <= cmd_d;
         rsp_q       <= rsp_d;
         disc_q      <= disc_d;
         valid_q     <= valid_d;
         disc_lat_q  <= disc_lat_d;
         valid_lat_q <= valid_lat_d;
         ctrl_q      <= ctrl_d;
         istat_q     <= istat_d;
         ien_q       <= ien_d;
         o_wb_ack    <= ack_d;
         o_wb_dat    <= rdat_d;
      end
   end

   // outputs
   assign o_tx_enable = ctrl_q[CTRL_TXEN_BIT];
   assign o_irq       = |(istat_q & ien_q);

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_in_cmd;
      st_q == ST_CMD;
   endsequence
   sequence s_init_fail;
      s_in_cmd ##0 (!i_evt.line_clear && i_evt.init_err);
   endsequence

   AST_INIT_ERR: assert property (
      s_init_fail |=> cmd_q[CMD_INIT_BIT] && st_q == ST_IGNORE)
      else $error("init error not flagged");
   AST_IGNORE_QUIET: assert property (
      st_q == ST_IGNORE |=> $stable(disc_q) || $past(disc_rd))
      else $error("ignored frame counted");
   AST_TXDIS: assert property (
      s_in_cmd ##0 (!i_evt.line_clear && !i_evt.init_err && !i_evt.byte_err
      && !i_evt.crc_err && i_evt.frame_ok && i_evt.is_read && !o_tx_enable)
      |=> cmd_q[CMD_TXDIS_BIT])
      else $error("tx disabled read not flagged");
   AST_CMD_SOF: assert property (
      s_in_cmd ##0 i_evt.line_clear |=> cmd_q[CMD_SOF_BIT] && st_q == ST_IDLE)
      else $error("command early clear not flagged");
   AST_CRC_DISC: assert property (
      s_in_cmd ##0 (!i_evt.line_clear && !i_evt.init_err && !i_evt.byte_err
      && i_evt.crc_err && !disc_rd && disc_q != DISC_MAX)
      |=> cmd_q[CMD_CRC_BIT] && disc_q == $past(disc_q) + 8'h01)
      else $error("crc discard not counted");
   AST_TX_SOF: assert property (
      st_q == ST_TX && i_evt.line_clear |=> rsp_q[CLEAR_DURING_TRANSMIT_ERROR_BIT])
      else $error("clear during transmit not flagged");
   AST_WAIT_ABORT: assert property (
      st_q == ST_WAIT && (i_evt.line_clear || i_evt.cmd_start)
      |=> rsp_q[PENDING_RESPONSE_ABORTED_BIT])
      else $error("pending abort not flagged");
   AST_RSP_MDROP: assert property (
      st_q == ST_RSP |-> ctrl_q[CTRL_MDROP_BIT] || $past(ctrl_q[CTRL_MDROP_BIT]))
      else $error("response tracked outside multidrop");
   // ack is registered on the taking edge, so it stands in the cycle after
   AST_DISC_RESET: assert property (
      disc_rd && !cnt_disc && !cnt_valid
      |=> o_wb_ack && disc_q == 8'h00 && valid_q == 16'h0000
      && valid_lat_q == $past(valid_q))
      else $error("discard read did not latch and reset");
   // latched copies only move on a discard read
   AST_VALID_HOLD: assert property (
      !disc_rd |=> $stable(valid_lat_q))
      else $error("valid latch moved without discard read");
   AST_VALID_SAT: assert property (
      valid_q == VALID_MAX && !disc_rd |=> valid_q == VALID_MAX)
      else $error("valid counter wrapped");
   AST_STICKY: assert property (
      cmd_q[CMD_CRC_BIT] && !(wr_hit && idx == IDX_CLR_CMD)
      |=> cmd_q[CMD_CRC_BIT])
      else $error("flag dropped without clear");

   ////////////////////////////////////////////////////////////////////
   // further checks: remaining frame paths, counters, bus ack and interrupt
   // byte error in a command frame drops the rest of it
   AST_CMD_BYTE: assert property (
      s_in_cmd ##0 (!i_evt.line_clear && !i_evt.init_err && i_evt.byte_err)
      |=> cmd_q[CMD_BYTE_BIT] && st_q == ST_IGNORE)
      else $error("command byte error not flagged");
   // ignored frame raises nothing at all
   AST_IGNORE_FLAGS: assert property (
      st_q == ST_IGNORE |-> cmd_set == 8'h00 && rsp_set == 8'h00)
      else $error("ignored frame raised a flag");
   AST_IGNORE_VALID: assert property (
      st_q == ST_IGNORE |=> $stable(valid_q) || $past(disc_rd))
      else $error("ignored frame counted valid");
   // response side mirrors the command side
   AST_RSP_SOF: assert property (
      st_q == ST_RSP && i_evt.line_clear |=> rsp_q[RESPONSE_EARLY_CLEAR_ERROR_BIT] && st_q == ST_IDLE)
      else $error("response early clear not flagged");
   AST_RSP_BYTE: assert property (
      st_q == ST_RSP && !i_evt.line_clear && i_evt.byte_err
      |=> rsp_q[RR_BYTE_BIT] && st_q == ST_IGNORE)
      else $error("response byte error not flagged");
   AST_RSP_CRC: assert property (
      st_q == ST_RSP && !i_evt.line_clear && !i_evt.init_err
      && !i_evt.byte_err && i_evt.crc_err |=> rsp_q[RESPONSE_CHECKSUM_ERROR_BIT])
      else $error("response crc not flagged");
   // discard count sticks at full scale, a wrap would hide a storm
   AST_DISC_SAT: assert property (
      disc_q == DISC_MAX && !disc_rd |=> disc_q == DISC_MAX)
      else $error("discard counter wrapped");
   // finished transmit counts one valid frame
   AST_TX_DONE: assert property (
      st_q == ST_TX && !i_evt.line_clear && i_evt.tx_done && !disc_rd
      && valid_q != VALID_MAX |=> valid_q == $past(valid_q) + 16'h0001)
      else $error("transmitted frame not counted");
   // bus answers exactly once per access
   AST_ACK_ONE: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   // enabled command event must reach the interrupt pin
   AST_IRQ_SET: assert property (
      (|cmd_set) && ien_q[INT_CMD_BIT] && !(wr_hit && idx == IDX_INT_EN)
      |=> o_irq)
      else $error("enabled event gave no interrupt");
endmodule

// [tb/link_framer_model.sv]
// Purpose: far-side framer stand-in issuing link event pulses
// Assumes: one request per cycle, same clock as the monitor
// Notes:   frame order is chosen by the bench, wrong orders on purpose too
`timescale 1ns/1ps
module link_framer_model
   import uart_err_mon_pkg::*;
(
   input  wire logic         i_ref_clk, // core clock
   input  wire logic         i_nrst,    // sync reset, active low
   input  wire logic         i_fire,    // send one pulse next cycle
   input  wire link_evt_type i_req,     // event to send
   output link_evt_type      o_evt_q    // one-cycle pulses to monitor
);
   link_evt_type evt_d;
   ////////////////////////////////////////////////////////////////////////
   // idle is all zero so a pulse never lingers past its cycle
   always_comb begin
      evt_d = '0;
      if (i_fire) begin
         evt_d = i_req;
      end
   end
   // registered so the monitor sees clean same-clock pulses
   always_ff @(posedge i_ref_clk) begin
      o_evt_q <= i_nrst ? evt_d : '0;
   end
endmodule

// [tb/uart_err_mon_test.sv]
// Purpose: self-checking bench for the uart link error monitor
// Assumes: classic wishbone master, framer model on the event side
// Notes:   saturation at full count is left to the design assertions
`timescale 1ns/1ps
module uart_err_mon_test;
   import uart_err_mon_pkg::*;
   localparam logic [9:0] E_CMD = 10'h200, E_RSP = 10'h100, E_INIT = 10'h080;
   localparam logic [9:0] E_BYTE = 10'h040, E_CRC = 10'h020, E_OK = 10'h010;
   localparam logic [9:0] E_RD = 10'h008, E_CLR = 10'h004, E_TXS = 10'h002;
   localparam logic [10:0] RST_IDX [6] = '{IDX_CMD_FLAGS, IDX_RSP_FLAGS,
      IDX_DISCARD, IDX_VALID_HI, IDX_VALID_LO, 11'h7FF};
   logic         clk, nrst, cyc, stb, we, ack, txen, irq, fire;
   logic [12:0]  adr;
   logic [3:0]   sel;
   logic [31:0]  wdat, rdat;
   link_evt_type req, evt;
   int           fail_count, total_checks, cycles, n;
   logic [7:0]   exp_d;
   logic [15:0]  exp_v;
   ////////////////////////////////////////////////////////////////////////
   uart_err_mon i_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_evt(evt), .o_tx_enable(txen), .o_irq(irq));
   link_framer_model i_far (.i_ref_clk(clk), .i_nrst(nrst), .i_fire(fire),
      .i_req(req), .o_evt_q(evt));
   // clock and hang guard; ceiling is far above the planned run
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic cycle; entered and left just after a rising edge
   task automatic wb(input logic w, input logic [10:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
      int k;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      wdat <= {24'h000000, wd};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 1000);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [10:0] idx, input logic [7:0] d);
      logic [7:0] x;
      wb(1'b1, idx, d, x);
   endtask
   task automatic rd_chk(input logic [10:0] idx, input logic [7:0] exp);
      logic [7:0] x;
      wb(1'b0, idx, 8'h00, x);
      chk8(x, exp);
   endtask
   // back-to-back event pulses, zero entries skipped
   task automatic evs(input logic [9:0] s [4]);
      foreach (s[i]) begin
         if (s[i] != 10'h000) begin
            fire <= 1'b1;
            req  <= link_evt_type'(s[i]);
            @(posedge clk);
         end
      end
      fire <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wipe();
      wr(IDX_CLR_CMD, 8'hFF);
      wr(IDX_CLR_RSP, 8'hFF);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {nrst, cyc, stb, we, fire, adr, wdat, fail_count, total_checks, cycles} = '0;
      sel = 4'hF;
      req = '0;
      void'($urandom(32'hB8D5));
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      foreach (RST_IDX[i]) rd_chk(RST_IDX[i], FLAGS_RST);
      rd_chk(IDX_CTRL, CTRL_RST);
      $display("test reset done");
      evs('{E_CMD, E_INIT, E_CRC, E_OK});
      rd_chk(IDX_CMD_FLAGS, 8'h20);
      rd_chk(IDX_DISCARD, 8'h00);
      evs('{E_CLR, 0, 0, 0});
      rd_chk(IDX_CMD_FLAGS, 8'h20);
      evs('{E_CMD, E_BYTE, E_OK, E_CLR});
      rd_chk(IDX_CMD_FLAGS, 8'h24);
      rd_chk(IDX_DISCARD, 8'h00);
      rd_chk(IDX_VALID_LO, 8'h00);
      wipe();
      rd_chk(IDX_CMD_FLAGS, 8'h00);
      $display("test ignore done");
      evs('{E_CMD, E_CRC, 0, 0});
      rd_chk(IDX_CMD_FLAGS, 8'h01);
      rd_chk(IDX_DISCARD, 8'h01);
      evs('{E_CMD, E_CLR, 0, 0});
      rd_chk(IDX_CMD_FLAGS, 8'h09);
      wipe();
      wr(IDX_CTRL, 8'h00);
      chk1(txen, 1'b0);
      evs('{E_CMD, E_OK | E_RD, 0, 0});
      rd_chk(IDX_CMD_FLAGS, 8'h10);
      wr(IDX_CTRL, 8'h01);
      $display("test command done");
      evs('{E_CMD, E_OK | E_RD, E_CLR, 0});
      rd_chk(IDX_RSP_FLAGS, 8'h08);
      wipe();
      evs('{E_CMD, E_OK | E_RD, E_CMD, E_CRC});
      rd_chk(IDX_RSP_FLAGS, 8'h08);
      wipe();
      evs('{E_CMD, E_OK | E_RD, E_TXS, E_CLR});
      rd_chk(IDX_RSP_FLAGS, 8'h10);
      wipe();
      evs('{E_RSP, E_CLR, 0, 0});
      rd_chk(IDX_RSP_FLAGS, 8'h00);
      rd_chk(IDX_DISCARD, 8'h02);
      wr(IDX_CTRL, 8'h03);
      evs('{E_RSP, E_CLR, 0, 0});
      rd_chk(IDX_RSP_FLAGS, 8'h04);
      evs('{E_RSP, E_BYTE, E_CRC, E_CLR});
      rd_chk(IDX_RSP_FLAGS, 8'h06);
      evs('{E_RSP, E_CRC, 0, 0});
      rd_chk(IDX_RSP_FLAGS, 8'h07);
      rd_chk(IDX_DISCARD, 8'h01);
      $display("test response done");
      // interrupt raised, masked, cleared while the flags keep holding
      wr(IDX_INT_EN, 8'h02);
      chk1(irq, 1'b1);
      wr(IDX_INT_EN, 8'h00);
      chk1(irq, 1'b0);
      wr(IDX_INT_EN, 8'h02);
      wr(IDX_INT_CLR, 8'h02);
      chk1(irq, 1'b0);
      rd_chk(IDX_RSP_FLAGS, 8'h07);
      wipe();
      $display("test interrupt done");
      // random mix of good and bad write frames, then latch and zero
      n = $urandom_range(40, 10);
      exp_d = 8'h00;
      exp_v = 16'h0000;
      for (int i = 0; i < n; i++) begin
         if ($urandom_range(1, 0) == 1) begin
            evs('{E_CMD, E_OK, 0, 0});
            exp_v++;
         end else begin
            evs('{E_CMD, E_CRC, 0, 0});
            exp_d++;
         end
      end
      rd_chk(IDX_DISCARD, exp_d);
      rd_chk(IDX_VALID_HI, exp_v[15:8]);
      rd_chk(IDX_VALID_LO, exp_v[7:0]);
      rd_chk(IDX_DISCARD, 8'h00);
      rd_chk(IDX_VALID_LO, 8'h00);
      $display("test counters done");
      complete_run();
   end
endmodule
